/* timer_pwm_pkg.sv */
// Shared offsets, field positions, reset values and encodings of the compare/PWM timer
package timer_pwm_pkg;

  localparam int unsigned CNT_W      = 16;
  localparam int unsigned NUM_CH     = 4;
  localparam int unsigned PRESC_W    = 6;

  // Register byte offsets
  localparam logic [7:0] OFS_TIMER_CTRL = 8'h20;
  localparam logic [7:0] OFS_DMA_SEL    = 8'h21;
  localparam logic [7:0] OFS_CNT_HI     = 8'h22;
  localparam logic [7:0] OFS_CNT_LO     = 8'h23;
  localparam logic [7:0] OFS_MOD_HI     = 8'h24;
  localparam logic [7:0] OFS_MOD_LO     = 8'h25;
  localparam logic [7:0] OFS_CH_BASE    = 8'h26;
  localparam logic [7:0] OFS_CH_STRIDE  = 8'h03;
  localparam logic [7:0] OFS_CH_HI      = 8'h01;
  localparam logic [7:0] OFS_CH_LO      = 8'h02;

  // timer_control_status fields
  localparam int unsigned TC_FLAG_BIT = 7;
  localparam int unsigned TC_IE_BIT   = 6;
  localparam int unsigned TC_HALT_BIT = 5;
  localparam int unsigned TC_RST_BIT  = 4;
  localparam int unsigned TC_PS_LSB   = 0;
  localparam int unsigned TC_PS_W     = 3;

  // chanN_control_status fields
  localparam int unsigned CC_FLAG_BIT  = 7;
  localparam int unsigned CC_IE_BIT    = 6;
  localparam int unsigned CC_LINK_BIT  = 5;
  localparam int unsigned CC_UNBUF_BIT = 4;
  localparam int unsigned CC_ACT_LSB   = 2;
  localparam int unsigned CC_TOV_BIT   = 1;
  localparam int unsigned CC_MAX_BIT   = 0;

  // Reset values
  localparam logic [7:0]       TIMER_CTRL_RST = 8'h20;
  localparam logic [CNT_W-1:0] MOD_RST        = 16'hffff;
  localparam logic [7:0]       CH_CTRL_RST    = 8'h00;
  localparam logic [CNT_W-1:0] CH_VAL_RST     = 16'h0000;

  // Prescaler code that selects the external clock pin
  localparam logic [2:0] PS_EXT_PIN = 3'h7;

  typedef enum logic [1:0] {
    ACT_NONE   = 2'b00,
    ACT_TOGGLE = 2'b01,
    ACT_CLEAR  = 2'b10,
    ACT_SET    = 2'b11
  } compare_action_t;

  // chan_mode_select codes
  localparam logic [1:0] MODE_UNBUFFERED = 2'b01;
  localparam logic [1:0] MODE_BUFFERED   = 2'b10;

endpackage

/* chan_output_unit.sv */
// Output-compare pin state for one timer channel
`timescale 1ns/1ps
module chan_output_unit (
  // Clock and reset
  input  wire logic                           core_clk,
  input  wire logic                           srst,
  // Events
  input  wire logic                           cmp_evt,
  input  wire logic                           ovf_evt,
  // Configuration
  input  wire logic                           enable,
  input  wire timer_pwm_pkg::compare_action_t action,
  input  wire logic                           toggle_on_overflow,
  input  wire logic                           max_duty_select,
  // Pin
  output logic                                pin_out,
  output logic                                pin_oe
);
  import timer_pwm_pkg::*;

  logic pin_state;
  logic next_pin_state;

  always_comb begin
    next_pin_state = pin_state;
    // No toggle without the overflow bit, so later set or clear compares only re-force the level
    if (ovf_evt && toggle_on_overflow) begin
      next_pin_state = ~pin_state;
    end
    if (cmp_evt) begin
      unique case (action)
        ACT_TOGGLE: next_pin_state = ~next_pin_state;
        ACT_CLEAR:  next_pin_state = 1'b0;
        ACT_SET:    next_pin_state = 1'b1;
        ACT_NONE:   next_pin_state = next_pin_state;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_state <= 1'b0;
    end else if (enable) begin
      pin_state <= next_pin_state;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
    end else begin
      pin_oe  <= enable;
      pin_out <= (max_duty_select && !toggle_on_overflow) ? 1'b1 : next_pin_state;
    end
  end

endmodule

/* timer_buffered_compare_pwm.sv */
// Four-channel 16-bit timer with buffered and unbuffered compare and PWM
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
module timer_buffered_compare_pwm #(
  parameter int unsigned NUM_CHAN = 4
) (
  // Clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            srst,
  // Register port
  input  wire logic [7:0]                      reg_addr,
  input  wire logic [7:0]                      reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output logic      [7:0]                      reg_rdata,
  // External timer clock pin
  input  wire logic                            ext_clk_pin,
  // Channel pins
  output logic      [timer_pwm_pkg::NUM_CH-1:0] chan_pin_out,
  output logic      [timer_pwm_pkg::NUM_CH-1:0] chan_pin_oe
);
  import timer_pwm_pkg::*;

  if (NUM_CHAN != NUM_CH) begin : g_bad_chan
    $error("NUM_CHAN must equal the built channel count");
  end

  // Timer control state
  logic               overflow_flag;
  logic               ovf_armed;
  logic               overflow_ie;
  logic               counter_halt;
  logic [TC_PS_W-1:0] prescale_sel;
  logic [CNT_W-1:0]   counter_modulo_value;
  logic [CNT_W-1:0]   count;
  logic [CNT_W-1:0]   next_count;
  logic [PRESC_W-1:0] presc;
  logic [PRESC_W-1:0] presc_mask;
  logic               ext_prev;
  logic               tick;
  logic               ovf_evt;
  logic               wr_tc;
  logic               counter_reset;

  // Channel state
  logic [7:0]       chan_ctrl [NUM_CH];
  logic [CNT_W-1:0] chan_compare_value [NUM_CH];
  logic [NUM_CH-1:0] chan_flag;
  logic [NUM_CH-1:0] flag_armed;
  logic [NUM_CH-1:0] hi_written;
  logic [NUM_CH-1:0] lo_written;
  logic [NUM_CH-1:0] pair_done;
  logic [NUM_CH-1:0] cmp_evt;
  logic [NUM_CH-1:0] chan_enable;
  logic [NUM_CH-1:0] ctrl_hit;
  logic [NUM_CH-1:0] hi_hit;
  logic [NUM_CH-1:0] lo_hit;
  logic [1:0]        pair_linked;
  logic [1:0]        upper_active;
  logic [1:0]        upper_last;

  assign wr_tc         = reg_wr && (reg_addr == OFS_TIMER_CTRL);
  assign counter_reset = wr_tc && reg_wdata[TC_RST_BIT];

  // Prescaler: tap N below 7 fires once every 2**N core clocks; code 7 follows the external pin
  assign presc_mask = PRESC_W'((7'h01 << prescale_sel) - 7'h01);
  assign tick = !counter_halt && ((prescale_sel == PS_EXT_PIN) ?
                (ext_clk_pin && !ext_prev) : ((presc & presc_mask) == presc_mask));
  assign next_count = (count == counter_modulo_value) ? '0 : count + 16'h0001;
  assign ovf_evt    = tick && (count == counter_modulo_value);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_clk_pin;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      presc <= '0;
      count <= '0;
    end else if (counter_reset) begin
      presc <= '0;
      count <= '0;
    end else begin
      if (!counter_halt) begin
        presc <= presc + 6'h01;
      end
      if (tick) begin
        count <= next_count;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      overflow_ie  <= TIMER_CTRL_RST[TC_IE_BIT];
      counter_halt <= TIMER_CTRL_RST[TC_HALT_BIT];
      prescale_sel <= TIMER_CTRL_RST[TC_PS_LSB +: TC_PS_W];
    end else if (wr_tc) begin
      overflow_ie  <= reg_wdata[TC_IE_BIT];
      counter_halt <= reg_wdata[TC_HALT_BIT];
      prescale_sel <= reg_wdata[TC_PS_LSB +: TC_PS_W];
    end
  end

  // Flag clears only by read-while-set then write 0; a fresh overflow wins
  always_ff @(posedge core_clk) begin
    if (srst) begin
      overflow_flag <= 1'b0;
      ovf_armed     <= 1'b0;
    end else if (ovf_evt) begin
      overflow_flag <= 1'b1;
      ovf_armed     <= 1'b0;
    end else if (wr_tc && !reg_wdata[TC_FLAG_BIT] && ovf_armed) begin
      overflow_flag <= 1'b0;
      ovf_armed     <= 1'b0;
    end else if (reg_rd && reg_addr == OFS_TIMER_CTRL && overflow_flag) begin
      ovf_armed <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      counter_modulo_value <= MOD_RST;
    end else if (reg_wr && reg_addr == OFS_MOD_HI) begin
      counter_modulo_value[15:8] <= reg_wdata;
    end else if (reg_wr && reg_addr == OFS_MOD_LO) begin
      counter_modulo_value[7:0] <= reg_wdata;
    end
  end

  // Pair linking and overflow-synchronised handover
  for (genvar p = 0; p < 2; p++) begin : g_pair
    assign pair_linked[p] = chan_ctrl[2*p][CC_LINK_BIT];

    always_ff @(posedge core_clk) begin
      if (srst || !pair_linked[p]) begin
        upper_active[p] <= 1'b0;
        upper_last[p]   <= 1'b0;
      end else begin
        if (pair_done[2*p+1]) begin
          upper_last[p] <= 1'b1;
        end else if (pair_done[2*p]) begin
          upper_last[p] <= 1'b0;
        end
        if (ovf_evt) begin
          // Switch only at period start, never mid-period
          upper_active[p] <= pair_done[2*p+1] ? 1'b1 :
                             pair_done[2*p] ? 1'b0 : upper_last[p];
        end
      end
    end
  end

  for (genvar i = 0; i < NUM_CH; i++) begin : g_chan
    localparam logic [7:0] CTRL_OFS = 8'(OFS_CH_BASE + OFS_CH_STRIDE * i);
    localparam bit         IS_UPPER = (i % 2) == 1;
    logic [CNT_W-1:0]      governing_value;
    logic [1:0]            mode_bits;

    assign ctrl_hit[i] = (reg_addr == CTRL_OFS);
    assign hi_hit[i]   = (reg_addr == 8'(CTRL_OFS + OFS_CH_HI));
    assign lo_hit[i]   = (reg_addr == 8'(CTRL_OFS + OFS_CH_LO));
    assign mode_bits   = {chan_ctrl[i][CC_LINK_BIT], chan_ctrl[i][CC_UNBUF_BIT]};

    if (IS_UPPER) begin : g_upper
      // Linked upper channel: control ignored, pin handed back
      assign chan_enable[i] = !pair_linked[i/2] && (mode_bits == MODE_UNBUFFERED) &&
                              (chan_ctrl[i][CC_ACT_LSB +: 2] != ACT_NONE);
      assign governing_value = chan_compare_value[i];
    end else begin : g_lower
      // Link bit overrides the unbuffered bit
      assign chan_enable[i] = (pair_linked[i/2] || mode_bits == MODE_UNBUFFERED) &&
                              (chan_ctrl[i][CC_ACT_LSB +: 2] != ACT_NONE);
      assign governing_value = (pair_linked[i/2] && upper_active[i/2]) ?
                               chan_compare_value[i+1] : chan_compare_value[i];
    end

    // Match only on reaching the value; a value already passed waits a period
    assign cmp_evt[i] = chan_enable[i] && tick && (next_count == governing_value);

    always_ff @(posedge core_clk) begin
      if (srst) begin
        chan_ctrl[i] <= CH_CTRL_RST;
      end else if (reg_wr && ctrl_hit[i]) begin
        chan_ctrl[i] <= {1'b0, reg_wdata[6], IS_UPPER ? 1'b0 : reg_wdata[5], reg_wdata[4:0]};
      end
    end

    always_ff @(posedge core_clk) begin
      if (srst) begin
        chan_compare_value[i] <= CH_VAL_RST;
      end else if (reg_wr && hi_hit[i]) begin
        chan_compare_value[i][15:8] <= reg_wdata;
      end else if (reg_wr && lo_hit[i]) begin
        chan_compare_value[i][7:0] <= reg_wdata;
      end
    end

    // Both bytes since the last handover make the pair count as written
    assign pair_done[i] = (hi_written[i] || (reg_wr && hi_hit[i])) &&
                          (lo_written[i] || (reg_wr && lo_hit[i]));
    always_ff @(posedge core_clk) begin
      if (srst || ovf_evt || pair_done[i]) begin
        hi_written[i] <= 1'b0;
        lo_written[i] <= 1'b0;
      end else begin
        hi_written[i] <= hi_written[i] || (reg_wr && hi_hit[i]);
        lo_written[i] <= lo_written[i] || (reg_wr && lo_hit[i]);
      end
    end

    always_ff @(posedge core_clk) begin
      if (srst) begin
        chan_flag[i]  <= 1'b0;
        flag_armed[i] <= 1'b0;
      end else if (cmp_evt[i]) begin
        chan_flag[i]  <= 1'b1;
        flag_armed[i] <= 1'b0;
      end else if (reg_wr && ctrl_hit[i] && !reg_wdata[CC_FLAG_BIT] && flag_armed[i]) begin
        chan_flag[i]  <= 1'b0;
        flag_armed[i] <= 1'b0;
      end else if (reg_rd && ctrl_hit[i] && chan_flag[i]) begin
        flag_armed[i] <= 1'b1;
      end
    end

    chan_output_unit u_out (
      .core_clk           (core_clk),
      .srst               (srst),
      .cmp_evt            (cmp_evt[i]),
      .ovf_evt            (ovf_evt && chan_enable[i]),
      .enable             (chan_enable[i]),
      .action             (compare_action_t'(chan_ctrl[i][CC_ACT_LSB +: 2])),
      .toggle_on_overflow (chan_ctrl[i][CC_TOV_BIT]),
      .max_duty_select    (chan_ctrl[i][CC_MAX_BIT]),
      .pin_out            (chan_pin_out[i]),
      .pin_oe             (chan_pin_oe[i])
    );
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (srst || !reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= 8'h00;
      unique case (reg_addr)
        OFS_TIMER_CTRL: reg_rdata <= {overflow_flag, overflow_ie, counter_halt, 2'b00,
                                      prescale_sel};
        OFS_CNT_HI:     reg_rdata <= count[15:8];
        OFS_CNT_LO:     reg_rdata <= count[7:0];
        OFS_MOD_HI:     reg_rdata <= counter_modulo_value[15:8];
        OFS_MOD_LO:     reg_rdata <= counter_modulo_value[7:0];
        default: begin
          for (int k = 0; k < NUM_CH; k++) begin
            if (ctrl_hit[k]) begin
              reg_rdata <= {chan_flag[k], chan_ctrl[k][6:0]};
            end else if (hi_hit[k]) begin
              reg_rdata <= chan_compare_value[k][15:8];
            end else if (lo_hit[k]) begin
              reg_rdata <= chan_compare_value[k][7:0];
            end
          end
        end
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  AST_WRAP_TO_ZERO: assert property (
    ovf_evt && !counter_reset |=> count == '0)
    else $error("counter did not wrap to zero after modulo match");

  AST_FLAG_ON_OVF: assert property (
    ovf_evt |=> overflow_flag ##1 (overflow_flag || $past(ovf_armed)))
    else $error("overflow flag not set by overflow");

  AST_RESET_CLEARS: assert property (
    counter_reset |=> count == '0 && presc == '0 && !reg_rdata[TC_RST_BIT])
    else $error("counter reset did not clear counter and prescaler");

  AST_UNDIVIDED_TICK: assert property (
    !counter_halt && prescale_sel == 3'h0 && !counter_reset |-> tick)
    else $error("undivided clock did not advance the counter");

  AST_PIN1_RELEASED: assert property (
    pair_linked[0] |=> !chan_pin_oe[1])
    else $error("channel 1 pin driven while pair linked");

  AST_PIN3_RELEASED: assert property (
    pair_linked[1] |=> !chan_pin_oe[3])
    else $error("channel 3 pin driven while pair linked");

  AST_HOLD_MID_PERIOD: assert property (
    pair_linked[0] && $past(pair_linked[0]) && !$past(ovf_evt) |-> $stable(upper_active[0]))
    else $error("buffered handover happened mid-period");

  AST_HANDOVER_UPPER: assert property (
    pair_linked[0] && ovf_evt && upper_last[0] && !pair_done[0]
    && $past(pair_linked[0]) ##1 pair_linked[0] |-> upper_active[0])
    else $error("upper pair did not take over at overflow");

  AST_TOGGLE_ON_OVF: assert property (
    chan_enable[0] && ovf_evt && chan_ctrl[0][CC_TOV_BIT] && !cmp_evt[0]
    && !chan_ctrl[0][CC_MAX_BIT] ##1 !$changed(chan_ctrl[0]) |-> chan_pin_out[0] != $past(chan_pin_out[0]))
    else $error("pin did not toggle at overflow");

  AST_FULL_DUTY: assert property (
    chan_ctrl[0][CC_MAX_BIT] && !chan_ctrl[0][CC_TOV_BIT] |=> chan_pin_out[0]
    || $changed(chan_ctrl[0]))
    else $error("max duty did not hold pin high");

  COV_OVERFLOW:   cover property (ovf_evt ##[1:300] ovf_evt);
  COV_HANDOVER:   cover property (pair_linked[0] && ovf_evt && upper_last[0]);
  COV_COMPARE:    cover property (cmp_evt[0] ##[1:300] ovf_evt);
  COV_FLAG_CLEAR: cover property (overflow_flag ##1 !overflow_flag);

endmodule

/* pin_load_model.sv */
// Load model for the timer pins: pull-ups on the channel lines and an external count clock
`timescale 1ns/1ps
module pin_load_model (
  // Clock
  input  wire logic       core_clk,
  // Channel pins
  input  wire logic [3:0] chan_pin_out,
  input  wire logic [3:0] chan_pin_oe,
  output logic      [3:0] pin_level,
  // External count clock
  output logic            ext_clk_pin
);
  logic [1:0] div = 2'h0;

  // A released pin floats to the pull-up level, never to the last driven value
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_level[i] = chan_pin_oe[i] ? chan_pin_out[i] : 1'b1;
    end
  end

  // Quarter of the core rate, below the half-rate ceiling of the count input
  always @(posedge core_clk) begin
    div <= div + 2'h1;
  end
  assign ext_clk_pin = div[1];
endmodule

/* test_timer_buffered_compare_pwm.sv */
// Self-checking bench for the buffered compare and PWM timer
`timescale 1ns/1ps
module test_timer_buffered_compare_pwm;
  import timer_pwm_pkg::*;
  logic        core_clk = 1'b0;
  logic        srst;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        ext_clk_pin;
  logic [3:0]  chan_pin_out;
  logic [3:0]  chan_pin_oe;
  logic [3:0]  pin_level;
  int          err_total = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          hi;
  int          per;
  int          bad;
  logic [7:0]  rd_val;
  // Unbuffered rows: control byte, prescale code, width, expected high and period cycles
  logic [7:0]  u_ctrl [4] = '{8'h1a, 8'h1e, 8'h1a, 8'h1a};
  logic [2:0]  u_ps   [4] = '{3'h0, 3'h0, 3'h1, 3'h7};
  logic [15:0] u_val  [4] = '{16'h0080, 16'h0040, 16'h0040, 16'h0040};
  int          u_hi   [4] = '{128, 192, 128, 256};
  int          u_per  [4] = '{256, 256, 512, 1024};

  timer_buffered_compare_pwm #(.NUM_CHAN(4)) timer_buffered_compare_pwm_inst (
    .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clk_pin(ext_clk_pin),
    .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe));
  pin_load_model pin_load_model_inst (
    .core_clk(core_clk), .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe),
    .pin_level(pin_level), .ext_clk_pin(ext_clk_pin));

  always #5 core_clk = ~core_clk;

  task automatic results;
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Roughly twice the expected run length
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      $display("FAIL %0t run did not finish", $time);
      results;
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t register byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      err_total++;
      $display("FAIL %0t cycle count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t pin bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  // Read data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
    @(posedge core_clk);
  endtask

  // Stop, clear the count, program period and width, configure, then start
  task automatic setup(input int ch, input logic [15:0] v, input logic [7:0] c,
                       input logic [2:0] ps);
    logic [7:0] base;
    base = OFS_CH_BASE + 8'(ch) * OFS_CH_STRIDE;
    wr(OFS_TIMER_CTRL, 8'h30);
    wr(OFS_MOD_HI, 8'h00);
    wr(OFS_MOD_LO, 8'hff);
    wr(base + OFS_CH_HI, v[15:8]);
    wr(base + OFS_CH_LO, v[7:0]);
    wr(base, c);
    wr(OFS_TIMER_CTRL, {5'h00, ps});
  endtask

  // One whole period from a rising edge; returns just after the following rise
  task automatic measure(input int p, output int h, output int t);
    int n;
    h = 0;
    t = 0;
    n = 0;
    @(negedge core_clk);
    while (pin_level[p] !== 1'b0 && n < 3000) begin @(negedge core_clk); n++; end
    while (pin_level[p] !== 1'b1 && n < 3000) begin @(negedge core_clk); n++; end
    while (pin_level[p] === 1'b1 && n < 3000) begin h++; t++; @(negedge core_clk); n++; end
    while (pin_level[p] === 1'b0 && n < 3000) begin t++; @(negedge core_clk); n++; end
    @(posedge core_clk);
  endtask

  task automatic hold(input int p, input logic lvl, input int n, output int b);
    b = 0;
    repeat (n) begin
      @(negedge core_clk);
      if (pin_level[p] !== lvl) b++;
    end
    @(posedge core_clk);
  endtask

  // Linked pair: lower width first, upper takes over only at the next overflow
  task automatic run_pair(input int lo, input logic [7:0] c);
    logic [7:0] up;
    logic [7:0] d;
    up = OFS_CH_BASE + 8'(lo + 1) * OFS_CH_STRIDE;
    wr(up, 8'h1a);
    setup(lo, 16'h0040, c, 3'h0);
    measure(lo, hi, per);
    chk_n(hi, 64);
    chk_n(per, 256);
    chk_bit(chan_pin_oe[lo], 1'b1);
    chk_bit(chan_pin_oe[lo + 1], 1'b0);
    wr(up + OFS_CH_HI, 8'h00);
    wr(up + OFS_CH_LO, 8'hc0);
    repeat (96) @(posedge core_clk);
    chk_bit(pin_level[lo], 1'b0);
    measure(lo, hi, per);
    chk_n(hi, 192);
    wr(OFS_CH_BASE + 8'(lo) * OFS_CH_STRIDE + OFS_CH_HI, 8'h00);
    wr(OFS_CH_BASE + 8'(lo) * OFS_CH_STRIDE + OFS_CH_LO, 8'h20);
    measure(lo, hi, per);
    chk_n(hi, 32);
    rd(OFS_CH_BASE + 8'(lo) * OFS_CH_STRIDE, d);
    chk8(d, 8'h80 | c);
  endtask

  initial begin
    srst      = 1'b1;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    for (int a = 32; a <= 49; a++) begin
      rd(8'(a), rd_val);
      chk8(rd_val, (a == 32) ? TIMER_CTRL_RST : (a == 36 || a == 37) ? 8'hff : 8'h00);
    end
    // Unused and unmapped places ignore writes and read zero
    wr(OFS_DMA_SEL, 8'hff);
    wr(8'h40, 8'h55);
    rd(OFS_DMA_SEL, rd_val);
    chk8(rd_val, 8'h00);
    rd(8'h40, rd_val);
    chk8(rd_val, 8'h00);
    wr(OFS_TIMER_CTRL, 8'h00);
    repeat (50) @(posedge core_clk);
    wr(OFS_TIMER_CTRL, 8'h30);
    rd(OFS_CNT_HI, rd_val);
    chk8(rd_val, 8'h00);
    rd(OFS_CNT_LO, rd_val);
    chk8(rd_val, 8'h00);
    rd(OFS_TIMER_CTRL, rd_val);
    chk8(rd_val, 8'h20);
    for (int i = 0; i < 4; i++) begin
      setup(1, u_val[i], u_ctrl[i], u_ps[i]);
      measure(1, hi, per);
      measure(1, hi, per);
      chk_n(hi, u_hi[i]);
      chk_n(per, u_per[i]);
    end
    rd(OFS_TIMER_CTRL, rd_val);
    chk8(rd_val, 8'h87);
    wr(OFS_TIMER_CTRL, 8'h07);
    rd(OFS_TIMER_CTRL, rd_val);
    chk8(rd_val, 8'h07);
    // Moving the width below a count already passed loses that compare
    setup(1, 16'h00c0, 8'h1a, 3'h0);
    measure(1, hi, per);
    repeat (96) @(posedge core_clk);
    wr(OFS_CH_BASE + OFS_CH_STRIDE + OFS_CH_HI, 8'h00);
    wr(OFS_CH_BASE + OFS_CH_STRIDE + OFS_CH_LO, 8'h20);
    hold(1, 1'b1, 140, bad);
    chk_n(bad, 0);
    // Lengthen just after the overflow, then shorten once the compare has passed
    setup(1, 16'h0080, 8'h1a, 3'h0);
    measure(1, hi, per);
    wr(OFS_CH_BASE + OFS_CH_STRIDE + OFS_CH_LO, 8'hc0);
    measure(1, hi, per);
    chk_n(hi, 192);
    chk_n(per, 256);
    repeat (200) @(posedge core_clk);
    wr(OFS_CH_BASE + OFS_CH_STRIDE + OFS_CH_LO, 8'h40);
    measure(1, hi, per);
    chk_n(hi, 64);
    // Toggle on compare without overflow toggle flips the pin once per period
    setup(1, 16'h0040, 8'h14, 3'h0);
    measure(1, hi, per);
    measure(1, hi, per);
    chk_n(hi, 256);
    chk_n(per, 512);
    setup(1, 16'h0040, 8'h18, 3'h0);
    repeat (300) @(posedge core_clk);
    hold(1, 1'b0, 300, bad);
    chk_n(bad, 0);
    setup(1, 16'h0040, 8'h19, 3'h0);
    repeat (4) @(posedge core_clk);
    hold(1, 1'b1, 300, bad);
    chk_n(bad, 0);
    chk_bit(chan_pin_oe[1], 1'b1);
    setup(1, 16'h0040, 8'h0a, 3'h0);
    repeat (4) @(posedge core_clk);
    chk_bit(chan_pin_oe[1], 1'b0);
    run_pair(0, 8'h3a);
    run_pair(2, 8'h2a);
    results;
  end
endmodule
